// file: inc/dpr_pkg.sv
// constants and types for the per-port ds0 ram indirect access engine
package dpr_pkg;
	// ************************************************************
	// register map (byte addresses on the bus)
	// ************************************************************
	localparam logic [7:0] OFS_SEL = 8'h00;
	localparam logic [7:0] OFS_DATA = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam int ADDR_DEC_W = 8;
	// ************************************************************
	// indirect_select_control fields
	// ************************************************************
	localparam int SEL_IDX_LSB = 0;
	localparam int SEL_BANK_LSB = 8;
	localparam int SEL_DIR_BIT = 14;
	localparam int SEL_BUSY_BIT = 15;
	localparam logic SEL_DIR_READ = 1'b1;
	localparam logic [15:0] SEL_RST = 16'h0000;
	localparam logic [15:0] DATA_RST = 16'h0000;
	// ************************************************************
	// bank codes
	// ************************************************************
	localparam int BANK_W = 2;
	localparam logic [1:0] BANK_DATA = 2'h0;
	localparam logic [1:0] BANK_RX = 2'h1;
	localparam logic [1:0] BANK_TX = 2'h2;
	localparam logic [1:0] BANK_ILL = 2'h3;
	// ************************************************************
	// per-ds0 configuration word fields (rx and tx share the layout)
	// ************************************************************
	localparam int CFG_CH_LSB = 0;
	localparam int CFG_CH_W = 8;
	localparam int CFG_56K_BIT = 8;
	localparam int CFG_FAO_BIT = 9;
	localparam int CFG_LLB_BIT = 10;
	localparam int CFG_NLB_BIT = 11;
	localparam int CFG_V54_BIT = 12;
	localparam int CFG_BERT_BIT = 14;
	localparam int CFG_EN_BIT = 15;
	// data word halves
	localparam int DAT_RX_LSB = 0;
	localparam int DAT_TX_LSB = 8;
	// ************************************************************
	// port control register of this block
	// ************************************************************
	localparam int CTRL_RXU_BIT = 0;
	localparam int CTRL_TXU_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [7:0] BYTE_ONES = 8'hFF;
	localparam logic [7:0] LSB_MASK = 8'hFE;
	localparam logic [7:0] LSB_ONE = 8'h01;
	localparam logic [1:0] HRESP_OKAY = 2'h0;
	localparam int HTRANS_ACT_BIT = 1;
	typedef enum logic {ENG_IDLE, ENG_RUN} dpr_eng_e;
endpackage

// file: src/dpr_port_ram.sv
// per-port ds0 port ram: indirect access engine, ahb-lite slave and ds0 datapath
// Operation
// - select field picks bank: 00 data, 01 rx config, 10 tx config, 11 illegal.
// - direction 1 starts a fetch; busy held until word sits in data window.
// - direction 0 copies data window into selected bank/slot, then clears busy.
// - busy is read-only bit 15 and reads 1 throughout an access.
// - data window is 16 bits, carrying word written or read.
// - data word low byte holds last rx byte; used for network loopback.
// - data word high byte holds last tx byte; used for local loopback.
// - rx config bits 7:0 map the ds0 to an hdlc channel code, passed out unchanged.
// - unchannelized port uses slot 0 rx config channel for whole port.
// - rx 56k on channelized port withholds the lsb from hdlc and tester.
// - loop-pattern search always sees all eight bits.
// - rx config bit 12 includes the slot in loop-pattern search.
// - rx bit 10 loops tx byte to hdlc only when enabled and 64k.
// - rx bit 14 routes received bits to tester, minus lsb in 56k.
// - rx bit 15 activates slot; inactive slot still feeds search and tester.
// - unchannelized port uses slot 0 enable for the whole port.
// - tx config: channel 7:0, 56k 8, ones 9, netloop 11, tester 14, enable 15.
// - tx 56k on channelized slot sends seven bits from hdlc or tester, lsb forced to 1.
// - tx force-ones puts eight ones into the slot.
// - tx priority: netloop, then tester, then force-ones, then enable.
`timescale 1ns/1ps
`default_nettype none
module dpr_port_ram #(
	parameter int SLOT_W = 7
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic [1:0] hresp,
	input wire logic rx_slot_stb,
	input wire logic [SLOT_W-1:0] rx_slot_idx,
	input wire logic [7:0] rx_byte,
	output logic rx_hdlc_valid,
	output logic [7:0] rx_hdlc_chan,
	output logic [7:0] rx_hdlc_byte,
	output logic rx_hdlc_seven,
	output logic rx_tester_valid,
	output logic [7:0] rx_tester_byte,
	output logic rx_tester_seven,
	output logic v54_valid,
	output logic [7:0] v54_byte,
	input wire logic tx_slot_stb,
	input wire logic [SLOT_W-1:0] tx_slot_idx,
	input wire logic [7:0] tx_hdlc_byte,
	input wire logic [7:0] tx_tester_byte,
	output logic tx_out_valid,
	output logic [7:0] tx_out_byte,
	output logic [7:0] tx_out_chan,
	output logic tx_hdlc_taken,
	output logic tx_tester_taken
);
	localparam int DEPTH = 1 << SLOT_W;

	// ************************************************************
	// storage
	// ************************************************************
	logic [15:0] dat_q [DEPTH];
	logic [15:0] rxc_q [DEPTH];
	logic [15:0] txc_q [DEPTH];
	logic [SLOT_W-1:0] sel_idx_r;
	logic [1:0] sel_bank_r;
	logic sel_dir_r;
	logic busy_r;
	logic [15:0] window_r;
	logic [1:0] ctrl_r;
	dpr_pkg::dpr_eng_e eng_r;

	// ************************************************************
	// ahb-lite slave
	// ************************************************************
	logic ap_wr_r;
	logic ap_rd_r;
	logic [7:0] ap_addr_r;
	logic ap_take;
	logic sel_wr;
	logic data_wr;
	logic ctrl_wr;
	logic [31:0] rd_mux;

	assign ap_take = hsel && hready && htrans[dpr_pkg::HTRANS_ACT_BIT];
	assign sel_wr = ap_wr_r && (ap_addr_r == dpr_pkg::OFS_SEL);
	assign data_wr = ap_wr_r && (ap_addr_r == dpr_pkg::OFS_DATA);
	assign ctrl_wr = ap_wr_r && (ap_addr_r == dpr_pkg::OFS_CTRL);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ap_wr_r <= 1'b0;
			ap_rd_r <= 1'b0;
			ap_addr_r <= 8'h00;
		end else begin
			ap_wr_r <= ap_take && hwrite;
			ap_rd_r <= ap_take && !hwrite;
			if (ap_take) begin
				ap_addr_r <= haddr[dpr_pkg::ADDR_DEC_W-1:0];
			end
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (ap_addr_r)
			dpr_pkg::OFS_SEL: begin
				rd_mux[dpr_pkg::SEL_IDX_LSB +: SLOT_W] = sel_idx_r;
				rd_mux[dpr_pkg::SEL_BANK_LSB +: dpr_pkg::BANK_W] = sel_bank_r;
				rd_mux[dpr_pkg::SEL_DIR_BIT] = sel_dir_r;
				rd_mux[dpr_pkg::SEL_BUSY_BIT] = busy_r;
			end
			dpr_pkg::OFS_DATA: rd_mux[15:0] = window_r;
			dpr_pkg::OFS_CTRL: rd_mux[1:0] = ctrl_r;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// reads take one wait state so that hrdata comes from a flop
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hreadyout <= 1'b1;
			hrdata <= 32'h0000_0000;
			hresp <= dpr_pkg::HRESP_OKAY;
		end else begin
			hresp <= dpr_pkg::HRESP_OKAY;
			if (ap_take && !hwrite) begin
				hreadyout <= 1'b0;
			end else if (ap_rd_r) begin
				hreadyout <= 1'b1;
				hrdata <= rd_mux;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_r <= dpr_pkg::CTRL_RST;
		end else if (ctrl_wr) begin
			ctrl_r <= hwdata[1:0];
		end
	end

	// ************************************************************
	// indirect access engine
	// ************************************************************
	logic start;
	logic dat_stall;
	logic eng_do;

	// a select write while busy is dropped so a running access is never disturbed
	assign start = sel_wr && !busy_r;
	// the datapath owns the data bank on slot strobes, so host access waits while any strobe is high
	assign dat_stall = (sel_bank_r == dpr_pkg::BANK_DATA) && (rx_slot_stb || tx_slot_stb);
	assign eng_do = (eng_r == dpr_pkg::ENG_RUN) && !dat_stall;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sel_idx_r <= '0;
			sel_bank_r <= dpr_pkg::BANK_DATA;
			sel_dir_r <= 1'b0;
		end else if (start) begin
			sel_idx_r <= hwdata[dpr_pkg::SEL_IDX_LSB +: SLOT_W];
			sel_bank_r <= hwdata[dpr_pkg::SEL_BANK_LSB +: dpr_pkg::BANK_W];
			sel_dir_r <= hwdata[dpr_pkg::SEL_DIR_BIT];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			eng_r <= dpr_pkg::ENG_IDLE;
			busy_r <= 1'b0;
		end else begin
			case (eng_r)
				dpr_pkg::ENG_IDLE: begin
					if (start) begin
						eng_r <= dpr_pkg::ENG_RUN;
						busy_r <= 1'b1;
					end
				end
				dpr_pkg::ENG_RUN: begin
					if (eng_do) begin
						eng_r <= dpr_pkg::ENG_IDLE;
						busy_r <= 1'b0;
					end
				end
				default: begin
					eng_r <= dpr_pkg::ENG_IDLE;
					busy_r <= 1'b0;
				end
			endcase
		end
	end

	// data window: host writes when idle, engine loads on a read
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			window_r <= dpr_pkg::DATA_RST;
		end else if (eng_do && sel_dir_r == dpr_pkg::SEL_DIR_READ) begin
			case (sel_bank_r)
				dpr_pkg::BANK_DATA: window_r <= dat_q[sel_idx_r];
				dpr_pkg::BANK_RX: window_r <= rxc_q[sel_idx_r];
				dpr_pkg::BANK_TX: window_r <= txc_q[sel_idx_r];
				default: window_r <= window_r;
			endcase
		end else if (data_wr && !busy_r) begin
			window_r <= hwdata[15:0];
		end
	end

	logic eng_wr;
	assign eng_wr = eng_do && sel_dir_r != dpr_pkg::SEL_DIR_READ;

	// configuration banks are written only by the engine; no reset, software loads them
	always_ff @(posedge clk) begin
		if (eng_wr && sel_bank_r == dpr_pkg::BANK_RX) begin
			rxc_q[sel_idx_r] <= window_r;
		end
		if (eng_wr && sel_bank_r == dpr_pkg::BANK_TX) begin
			txc_q[sel_idx_r] <= window_r;
		end
	end

	// ************************************************************
	// ds0 datapath lookups
	// ************************************************************
	logic [SLOT_W-1:0] rx_ci;
	logic [SLOT_W-1:0] tx_ci;
	logic [15:0] rx_cfg;
	logic [15:0] tx_cfg;
	logic [7:0] rx_last_tx;
	logic [7:0] tx_last_rx;
	logic rx_unch;
	logic tx_unch;
	logic [7:0] tx_out_nxt;

	assign rx_unch = ctrl_r[dpr_pkg::CTRL_RXU_BIT];
	assign tx_unch = ctrl_r[dpr_pkg::CTRL_TXU_BIT];
	assign rx_ci = rx_unch ? '0 : rx_slot_idx;
	assign tx_ci = tx_unch ? '0 : tx_slot_idx;
	assign rx_cfg = rxc_q[rx_ci];
	assign tx_cfg = txc_q[tx_ci];
	assign rx_last_tx = dat_q[rx_slot_idx][dpr_pkg::DAT_TX_LSB +: 8];
	assign tx_last_rx = dat_q[tx_slot_idx][dpr_pkg::DAT_RX_LSB +: 8];

	// data bank: datapath halves first, host write only when not stalled
	always_ff @(posedge clk) begin
		if (eng_wr && sel_bank_r == dpr_pkg::BANK_DATA) begin
			dat_q[sel_idx_r] <= window_r;
		end
		if (rx_slot_stb) begin
			dat_q[rx_slot_idx][dpr_pkg::DAT_RX_LSB +: 8] <= rx_byte;
		end
		if (tx_slot_stb) begin
			dat_q[tx_slot_idx][dpr_pkg::DAT_TX_LSB +: 8] <= tx_out_nxt;
		end
	end

	// ************************************************************
	// receive side
	// ************************************************************
	logic rx_en;
	logic rx_56;
	logic rx_loop;
	logic [7:0] rx_src;

	assign rx_en = rx_cfg[dpr_pkg::CFG_EN_BIT];
	assign rx_56 = rx_cfg[dpr_pkg::CFG_56K_BIT] && !rx_unch;
	assign rx_loop = rx_cfg[dpr_pkg::CFG_LLB_BIT] && rx_en && !rx_56;
	assign rx_src = rx_loop ? rx_last_tx : rx_byte;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_hdlc_valid <= 1'b0;
			rx_hdlc_chan <= 8'h00;
			rx_hdlc_byte <= 8'h00;
			rx_hdlc_seven <= 1'b0;
		end else begin
			rx_hdlc_valid <= rx_slot_stb && rx_en;
			if (rx_slot_stb && rx_en) begin
				rx_hdlc_chan <= rx_cfg[dpr_pkg::CFG_CH_LSB +: dpr_pkg::CFG_CH_W];
				rx_hdlc_byte <= rx_56 ? (rx_src & dpr_pkg::LSB_MASK) : rx_src;
				rx_hdlc_seven <= rx_56;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_tester_valid <= 1'b0;
			rx_tester_byte <= 8'h00;
			rx_tester_seven <= 1'b0;
		end else begin
			rx_tester_valid <= rx_slot_stb && rx_cfg[dpr_pkg::CFG_BERT_BIT];
			if (rx_slot_stb && rx_cfg[dpr_pkg::CFG_BERT_BIT]) begin
				rx_tester_byte <= rx_56 ? (rx_byte & dpr_pkg::LSB_MASK) : rx_byte;
				rx_tester_seven <= rx_56;
			end
		end
	end

	// the search never follows the 56k or loopback setting
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			v54_valid <= 1'b0;
			v54_byte <= 8'h00;
		end else begin
			v54_valid <= rx_slot_stb && (rx_cfg[dpr_pkg::CFG_V54_BIT] || rx_unch);
			if (rx_slot_stb) begin
				v54_byte <= rx_byte;
			end
		end
	end

	// ************************************************************
	// transmit side
	// ************************************************************
	logic tx_56;
	logic tx_use_hdlc;
	logic tx_use_tester;

	assign tx_56 = tx_cfg[dpr_pkg::CFG_56K_BIT] && !tx_unch;

	always_comb begin
		tx_use_hdlc = 1'b0;
		tx_use_tester = 1'b0;
		if (tx_cfg[dpr_pkg::CFG_NLB_BIT]) begin
			tx_out_nxt = tx_last_rx;
		end else if (tx_cfg[dpr_pkg::CFG_BERT_BIT]) begin
			tx_use_tester = 1'b1;
			tx_out_nxt = tx_56 ? (tx_tester_byte | dpr_pkg::LSB_ONE) : tx_tester_byte;
		end else if (tx_cfg[dpr_pkg::CFG_FAO_BIT]) begin
			tx_out_nxt = dpr_pkg::BYTE_ONES;
		end else if (tx_cfg[dpr_pkg::CFG_EN_BIT]) begin
			tx_use_hdlc = 1'b1;
			tx_out_nxt = tx_56 ? (tx_hdlc_byte | dpr_pkg::LSB_ONE) : tx_hdlc_byte;
		end else begin
			tx_out_nxt = dpr_pkg::BYTE_ONES;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_out_valid <= 1'b0;
			tx_out_byte <= dpr_pkg::BYTE_ONES;
			tx_out_chan <= 8'h00;
			tx_hdlc_taken <= 1'b0;
			tx_tester_taken <= 1'b0;
		end else begin
			tx_out_valid <= tx_slot_stb;
			tx_hdlc_taken <= tx_slot_stb && tx_use_hdlc;
			tx_tester_taken <= tx_slot_stb && tx_use_tester;
			if (tx_slot_stb) begin
				tx_out_byte <= tx_out_nxt;
				tx_out_chan <= tx_cfg[dpr_pkg::CFG_CH_LSB +: dpr_pkg::CFG_CH_W];
			end
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	// a data-bank access may stall for as long as slot strobes run, so no fixed bound
	property p_busy_bounded;
		@(posedge clk) disable iff (!resetn)
		(busy_r && !dat_stall) |=> !busy_r;
	endproperty
	a_busy_bounded: assert property (p_busy_bounded) else $error("busy did not clear");

	property p_busy_state;
		@(posedge clk) disable iff (!resetn)
		busy_r == (eng_r == dpr_pkg::ENG_RUN);
	endproperty
	a_busy_state: assert property (p_busy_state) else $error("busy disagrees with engine");

	property p_rx_write;
		@(posedge clk) disable iff (!resetn)
		(eng_wr && sel_bank_r == dpr_pkg::BANK_RX) |=>
			rxc_q[$past(sel_idx_r)] == $past(window_r) && !busy_r;
	endproperty
	a_rx_write: assert property (p_rx_write) else $error("rx config write lost");

	property p_read_load;
		@(posedge clk) disable iff (!resetn)
		(eng_do && sel_dir_r && sel_bank_r == dpr_pkg::BANK_TX) |=>
			window_r == $past(txc_q[sel_idx_r]) && !busy_r;
	endproperty
	a_read_load: assert property (p_read_load) else $error("read word not in window");

	property p_illegal;
		@(posedge clk) disable iff (!resetn)
		(eng_do && sel_bank_r == dpr_pkg::BANK_ILL) |=> $stable(window_r) && !busy_r;
	endproperty
	a_illegal: assert property (p_illegal) else $error("illegal bank access had effect");

	property p_rx_seven;
		@(posedge clk) disable iff (!resetn)
		(rx_slot_stb && rx_en && rx_56) |=> rx_hdlc_valid && rx_hdlc_seven && !rx_hdlc_byte[0];
	endproperty
	a_rx_seven: assert property (p_rx_seven) else $error("56k lsb not withheld");

	property p_v54;
		@(posedge clk) disable iff (!resetn)
		(rx_slot_stb && rx_cfg[dpr_pkg::CFG_V54_BIT]) |=> v54_valid && v54_byte == $past(rx_byte);
	endproperty
	a_v54: assert property (p_v54) else $error("search did not see full byte");

	property p_rx_map;
		@(posedge clk) disable iff (!resetn)
		(rx_slot_stb && rx_en) |=> rx_hdlc_chan == $past(rx_cfg[7:0]);
	endproperty
	a_rx_map: assert property (p_rx_map) else $error("hdlc channel map wrong");

	property p_tx_loop;
		@(posedge clk) disable iff (!resetn)
		(tx_slot_stb && tx_cfg[dpr_pkg::CFG_NLB_BIT]) |=>
			tx_out_byte == $past(tx_last_rx) && !tx_hdlc_taken && !tx_tester_taken;
	endproperty
	a_tx_loop: assert property (p_tx_loop) else $error("network loop not first");

	property p_tx_ones;
		@(posedge clk) disable iff (!resetn)
		(tx_slot_stb && !tx_cfg[dpr_pkg::CFG_NLB_BIT] && !tx_cfg[dpr_pkg::CFG_BERT_BIT]
			&& tx_cfg[dpr_pkg::CFG_FAO_BIT]) |=> tx_out_byte == dpr_pkg::BYTE_ONES;
	endproperty
	a_tx_ones: assert property (p_tx_ones) else $error("force ones not applied");

	property p_tx_56;
		@(posedge clk) disable iff (!resetn)
		(tx_slot_stb && tx_56 && !tx_cfg[dpr_pkg::CFG_NLB_BIT]
			&& (tx_cfg[dpr_pkg::CFG_BERT_BIT] || tx_cfg[dpr_pkg::CFG_EN_BIT])) |=> tx_out_byte[0];
	endproperty
	a_tx_56: assert property (p_tx_56) else $error("tx 56k lsb not one");
endmodule
`default_nettype wire

// file: tb/ds0_port_ram_indirect_access_test.sv
// self-checking bench for the ds0 port ram indirect access engine
`timescale 1ns/1ps
`default_nettype none
module ds0_port_ram_indirect_access_test;
	// ************************************************************
	// stimulus and design
	// ************************************************************
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic [1:0] hresp;
	logic rx_slot_stb = 1'b0;
	logic [6:0] rx_slot_idx = 7'h0;
	logic [7:0] rx_byte = 8'h0;
	logic rx_hdlc_valid, rx_hdlc_seven, rx_tester_valid, rx_tester_seven, v54_valid;
	logic [7:0] rx_hdlc_chan, rx_hdlc_byte, rx_tester_byte, v54_byte;
	logic tx_slot_stb = 1'b0;
	logic [6:0] tx_slot_idx = 7'h0;
	logic [7:0] tx_hdlc_byte = 8'h0;
	logic [7:0] tx_tester_byte = 8'h0;
	logic tx_out_valid, tx_hdlc_taken, tx_tester_taken;
	logic [7:0] tx_out_byte, tx_out_chan;
	int errors = 0;
	int comparisons = 0;

	dpr_port_ram i_dut (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_slot_stb, .rx_slot_idx, .rx_byte,
		.rx_hdlc_valid, .rx_hdlc_chan, .rx_hdlc_byte, .rx_hdlc_seven, .rx_tester_valid,
		.rx_tester_byte, .rx_tester_seven, .v54_valid, .v54_byte, .tx_slot_stb, .tx_slot_idx,
		.tx_hdlc_byte, .tx_tester_byte, .tx_out_valid, .tx_out_byte, .tx_out_chan,
		.tx_hdlc_taken, .tx_tester_taken);

	always #25 clk = ~clk;

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic final_report();
		if (errors == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			$display("mismatch %0t %s", $time, what);
			errors++;
		end
	endtask

	// ready is looked at on the falling edge: a flop holds that value up to the rising edge
	task automatic wait_rdy(output logic [31:0] rd);
		logic r;
		int n;
		n = 0;
		r = 1'b0;
		while (r !== 1'b1) begin
			@(negedge clk);
			r = hreadyout;
			rd = hrdata;
			@(posedge clk);
			n++;
			if (n > 40) begin
				errors++;
				final_report();
			end
		end
	endtask

	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
		output logic [31:0] rd);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		hsel <= 1'b1;
		wait_rdy(rd);
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy(rd);
		chk({38'h0, hresp}, 40'h0, "response");
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] x;
		bus(a, 1'b1, {16'h0, d}, x);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		bus(a, 1'b0, 32'h0, d);
	endtask

	task automatic poll();
		logic [31:0] s;
		int n;
		n = 0;
		s = 32'hFFFF;
		while (s[15] !== 1'b0) begin
			rd(dpr_pkg::OFS_SEL, s);
			n++;
			if (n > 20) begin
				errors++;
				final_report();
			end
		end
	endtask

	task automatic ind(input logic [6:0] idx, input logic [1:0] bank, input logic dir);
		wr(dpr_pkg::OFS_SEL, {1'b0, dir, 4'h0, bank, 1'b0, idx});
		poll();
	endtask

	task automatic cw(input logic [6:0] idx, input logic [1:0] bank, input logic [15:0] v);
		wr(dpr_pkg::OFS_DATA, v);
		ind(idx, bank, 1'b0);
	endtask

	task automatic cr(input logic [6:0] idx, input logic [1:0] bank, output logic [31:0] v);
		ind(idx, bank, 1'b1);
		rd(dpr_pkg::OFS_DATA, v);
	endtask

	task automatic rx_send(input logic [6:0] idx, input logic [7:0] b, output logic [36:0] g);
		rx_slot_stb <= 1'b1;
		rx_slot_idx <= idx;
		rx_byte <= b;
		@(posedge clk);
		rx_slot_stb <= 1'b0;
		@(negedge clk);
		g = {rx_hdlc_valid, rx_hdlc_chan, rx_hdlc_byte, rx_hdlc_seven, rx_tester_valid,
			rx_tester_byte, rx_tester_seven, v54_valid, v54_byte};
		@(posedge clk);
	endtask

	task automatic tx_send(input logic [6:0] idx, output logic [18:0] t);
		tx_slot_stb <= 1'b1;
		tx_slot_idx <= idx;
		@(posedge clk);
		tx_slot_stb <= 1'b0;
		@(negedge clk);
		t = {tx_out_valid, tx_out_byte, tx_out_chan, tx_hdlc_taken, tx_tester_taken};
		@(posedge clk);
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic s_reset();
		logic [31:0] d;
		wr(8'h0C, 16'hFFFF);
		for (int a = 0; a < 16; a += 4) begin
			rd(a[7:0], d);
			chk(d, 40'h0, "reset or unmapped read");
		end
	endtask

	task automatic s_cfg_rw();
		logic [31:0] d;
		cw(7'h05, dpr_pkg::BANK_TX, 16'hA5C3);
		cw(7'h05, dpr_pkg::BANK_RX, 16'h1234);
		cr(7'h05, dpr_pkg::BANK_TX, d);
		chk(d, 40'hA5C3, "tx config readback");
		cr(7'h05, dpr_pkg::BANK_RX, d);
		chk(d, 40'h1234, "rx config readback");
	endtask

	task automatic s_rx();
		logic [36:0] g;
		cw(7'h05, dpr_pkg::BANK_RX, 16'hD0FF);
		rx_send(7'h05, 8'hA5, g);
		chk(g, {1'b1, 8'hFF, 8'hA5, 1'b0, 1'b1, 8'hA5, 1'b0, 1'b1, 8'hA5},
			"rx 64k");
		cw(7'h05, dpr_pkg::BANK_RX, 16'hD1FF);
		rx_send(7'h05, 8'hA5, g);
		chk(g, {1'b1, 8'hFF, 8'hA4, 1'b1, 1'b1, 8'hA4, 1'b1, 1'b1, 8'hA5},
			"rx 56k");
		cw(7'h05, dpr_pkg::BANK_RX, 16'h00FF);
		rx_send(7'h05, 8'hA5, g);
		chk({g[36], g[18], g[8]}, 40'h0, "rx slot off");
	endtask

	task automatic s_loop();
		logic [36:0] g;
		logic [18:0] t;
		logic [31:0] d;
		cw(7'h05, dpr_pkg::BANK_RX, 16'h8403);
		cw(7'h05, dpr_pkg::BANK_TX, 16'h8003);
		tx_hdlc_byte <= 8'h3C;
		tx_send(7'h05, t);
		chk(t, {1'b1, 8'h3C, 8'h03, 1'b1, 1'b0}, "tx from hdlc");
		rx_send(7'h05, 8'h11, g);
		chk({g[36], g[27:20]}, {1'b1, 8'h3C}, "local loop");
		cr(7'h05, dpr_pkg::BANK_DATA, d);
		chk(d, 40'h3C11, "ds0 data word");
	endtask

	task automatic s_tx();
		logic [18:0] t;
		logic [15:0] cfg [7] = '{16'h8007, 16'h8107, 16'h8207, 16'hC207, 16'hC107, 16'hCA07,
			16'h0007};
		logic [7:0] exp [7] = '{8'h5A, 8'h5B, 8'hFF, 8'hC2, 8'hC3, 8'h11, 8'hFF};
		logic [1:0] tk [7] = '{2'h2, 2'h2, 2'h0, 2'h1, 2'h1, 2'h0, 2'h0};
		tx_hdlc_byte <= 8'h5A;
		tx_tester_byte <= 8'hC2;
		for (int i = 0; i < 7; i++) begin
			cw(7'h05, dpr_pkg::BANK_TX, cfg[i]);
			tx_send(7'h05, t);
			chk(t[17:10], exp[i], "tx source");
			chk(t[1:0], tk[i], "tx source taken");
		end
	endtask

	task automatic s_ill();
		logic [31:0] d;
		wr(dpr_pkg::OFS_DATA, 16'hBEEF);
		ind(7'h05, dpr_pkg::BANK_ILL, 1'b0);
		cr(7'h05, dpr_pkg::BANK_RX, d);
		chk(d, 40'h8403, "illegal bank touched rx");
		cr(7'h05, dpr_pkg::BANK_TX, d);
		chk(d, 40'h0007, "illegal bank touched tx");
	endtask

	// a steady slot strobe stalls a data-bank access, so busy must still read high
	task automatic s_busy();
		logic [31:0] s;
		cw(7'h09, dpr_pkg::BANK_RX, 16'h0000);
		rx_slot_stb <= 1'b1;
		rx_slot_idx <= 7'h09;
		rx_byte <= 8'h6E;
		wr(dpr_pkg::OFS_SEL, 16'h4009);
		rd(dpr_pkg::OFS_SEL, s);
		chk(s[15], 40'h1, "busy during access");
		rx_slot_stb <= 1'b0;
		poll();
		rd(dpr_pkg::OFS_DATA, s);
		chk(s[7:0], 40'h6E, "stalled read word");
	endtask

	task automatic s_unch();
		logic [36:0] g;
		logic [31:0] d;
		cw(7'h00, dpr_pkg::BANK_RX, 16'h8042);
		wr(dpr_pkg::OFS_CTRL, 16'h0001);
		rd(dpr_pkg::OFS_CTRL, d);
		chk(d, 40'h1, "port control");
		rx_send(7'h07, 8'h81, g);
		chk({g[36:20], g[8]}, {1'b1, 8'h42, 8'h81, 1'b1}, "unchannelized rx");
		wr(dpr_pkg::OFS_CTRL, 16'h0000);
	endtask

	initial begin
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		s_reset();
		s_cfg_rw();
		s_rx();
		s_loop();
		s_tx();
		s_ill();
		s_busy();
		s_unch();
		final_report();
	end
endmodule
`default_nettype wire
